/* dv/ccs_sva.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// register link checker
// ----------------------------------------------------------------
module ccs_sva import ccs_pkg::*; (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic req, // host request
  input wire logic we, // write select
  input wire logic [7:0] addr, // register offset
  input wire logic [7:0] wdata, // write data
  input wire logic ack, // device answer
  input wire logic [7:0] rdata, // read data
  input wire logic interrupt_out_n // interrupt, active low
);
  logic [7:0] mask_reg;
  logic [7:0] gen_reg;
  logic rd_stat;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // shadow of the mask byte, one cycle behind the device copy
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) mask_reg <= ALL_CLEAR;
    else if (ack && we && addr == REG_EVENT_IRQ_MASK) mask_reg <= wdata;
  end
  // shadow of the generation enable byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) gen_reg <= RST_EVENT_GEN_ENABLE;
    else if (ack && we && addr == REG_EVENT_GEN_ENABLE) gen_reg <= wdata;
  end
  // status read taken on this edge
  assign rd_stat = req && !ack && !we && addr == REG_EVENT_STATUS;
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");
  a_ack_after_take: assert property (req && !ack |=> ack)
    else $error("request not answered on the next edge");
  a_ack_needs_req: assert property (ack |-> $past(req))
    else $error("ack without a request");
  a_req_held_stable: assert property (req && !ack |=> req && $stable(addr) && $stable(we))
    else $error("request changed before ack");
  a_req_gap_after: assert property (ack |=> !req)
    else $error("request not dropped after ack");
  a_rdata_held_idle: assert property (!ack |-> $stable(rdata))
    else $error("read data moved without ack");
  a_gen_gates_status: assert property (rd_stat |=> (rdata & ~gen_reg) == 8'h00)
    else $error("status bit set while generation is off");
  a_irq_has_cause: assert property (rd_stat && !interrupt_out_n |=> (rdata & mask_reg) != 8'h00)
    else $error("interrupt low with no masked status bit");
  a_irq_read_clear: assert property (rd_stat && !interrupt_out_n |=> ##[0:1] interrupt_out_n)
    else $error("interrupt stays low after status read");
  a_mask_zero_quiet: assert property ((mask_reg == ALL_CLEAR) [*3] |-> interrupt_out_n)
    else $error("interrupt low while mask is clear");
endmodule : ccs_sva

/* dv/ccs_test.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// host and device joined back to back
// ----------------------------------------------------------------
module ccs_test import ccs_pkg::*;;
  typedef struct {ccs_op_t op; logic [7:0] a; logic [7:0] d; logic [7:0] x;} ccs_row_t;
  logic clk, nrst, cmd_valid, cmd_ready, rsp_valid, in_valid, play_valid;
  ccs_op_t cmd_op;
  logic [7:0] cmd_addr, cmd_data, rsp_data, live_gain, port_ctrl;
  logic [15:0] in_left, in_right, play_sample;
  logic [3:0] rec_gain_left, rec_gain_right;
  logic port_en, mic_left_en, mic_right_en, lineout_en, amp_en, main_clk_run;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  ccs_row_t rows [18];
  ccs_if bus_if();
  ccs_host i_ccs_host (.clk(clk), .nrst(nrst), .bus(bus_if), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  // short ramp step keeps a full-scale volume swing to a few hundred cycles
  ccs_device #(.STEP_CYC(2), .SAMPLE_W(16)) i_ccs_device (.clk(clk), .nrst(nrst),
    .bus(bus_if), .in_left(in_left), .in_right(in_right), .in_valid(in_valid),
    .play_sample(play_sample), .play_valid(play_valid), .live_gain(live_gain),
    .rec_gain_left(rec_gain_left), .rec_gain_right(rec_gain_right), .port_ctrl(port_ctrl),
    .port_en(port_en), .mic_left_en(mic_left_en), .mic_right_en(mic_right_en),
    .lineout_en(lineout_en), .amp_en(amp_en), .main_clk_run(main_clk_run));
  ccs_sva chk_sva (.clk(clk), .nrst(nrst), .req(bus_if.req), .we(bus_if.we),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .ack(bus_if.ack), .rdata(bus_if.rdata),
    .interrupt_out_n(bus_if.interrupt_out_n));

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // a lost response would otherwise stall the run forever
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one host command, launched and finished on falling edges
  task automatic do_cmd(input ccs_op_t op, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) chk(16'h0001, 16'h0000);
  endtask : do_cmd
  task automatic wait_gain(input logic [7:0] g);
    int n;
    n = 0;
    while (live_gain !== g && n < 500) begin
      @(negedge clk);
      n++;
    end
    chk(16'(live_gain), 16'(g));
    // the done event lands one ramp tick after the last step
    repeat (3) @(negedge clk);
  endtask : wait_gain

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rows[0] = '{CCS_OP_READ, 8'h02, 8'h00, 8'h50};
    rows[1] = '{CCS_OP_READ, 8'h2A, 8'h00, 8'h80};
    rows[2] = '{CCS_OP_READ, 8'h01, 8'h00, 8'h00};
    rows[3] = '{CCS_OP_WRITE, 8'h09, 8'h98, 8'h00};
    rows[4] = '{CCS_OP_READ, 8'h09, 8'h00, 8'h98};
    rows[5] = '{CCS_OP_WRITE, 8'h0A, 8'h08, 8'h00};
    rows[6] = '{CCS_OP_READ, 8'h0A, 8'h00, 8'h08};
    rows[7] = '{CCS_OP_WRITE, 8'h0F, 8'hCC, 8'h00};
    rows[8] = '{CCS_OP_READ, 8'h0F, 8'h00, 8'hCC};
    rows[9] = '{CCS_OP_WRITE, 8'h32, 8'h2B, 8'h00};
    rows[10] = '{CCS_OP_READ, 8'h32, 8'h00, 8'h2B};
    rows[11] = '{CCS_OP_WRITE, 8'h33, 8'h01, 8'h00};
    rows[12] = '{CCS_OP_READ, 8'h00, 8'h00, 8'h10};
    rows[13] = '{CCS_OP_READ, 8'h00, 8'h00, 8'h00};
    rows[14] = '{CCS_OP_READ, 8'h33, 8'h00, 8'h00};
    rows[15] = '{CCS_OP_READ, 8'h5C, 8'h00, 8'h00};
    rows[16] = '{CCS_OP_WRITE, 8'h2A, 8'hD5, 8'h00};
    rows[17] = '{CCS_OP_READ, 8'h2A, 8'h00, 8'hD5};
    {nrst, cmd_valid, in_valid} = 3'b000;
    cmd_op = CCS_OP_READ;
    {cmd_addr, cmd_data} = 16'h0000;
    {in_left, in_right} = 32'h0000_0000;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    chk(16'(cmd_ready), 16'h0001);
    chk(16'(bus_if.interrupt_out_n), 16'h0001);
    foreach (rows[i]) begin
      do_cmd(rows[i].op, rows[i].a, rows[i].d);
      if (rows[i].op == CCS_OP_READ) chk(16'(rsp_data), 16'(rows[i].x));
    end
    chk({rec_gain_left, rec_gain_right}, 16'h00CC);
    chk({amp_en, mic_right_en, lineout_en, mic_left_en, port_en}, 16'h001B);
    chk({port_ctrl, 7'h00, main_clk_run}, 16'h9801);
    // negative left sample checks the mean is signed
    in_left = 16'hFF00;
    in_right = 16'h0300;
    in_valid = 1'b1;
    @(negedge clk);
    in_valid = 1'b0;
    chk({play_sample}, 16'h0100);
    chk(16'(play_valid), 16'h0001);
    wait_gain(8'hD5);
    do_cmd(CCS_OP_READ, REG_EVENT_STATUS, 8'h00);
    chk(16'(rsp_data), 16'h0040);
    do_cmd(CCS_OP_SHUT_POLL, 8'h00, 8'h00);
    chk(16'(rsp_data & 8'h40), 16'h0040);
    chk(16'(live_gain), 16'h0080);
    chk({amp_en, mic_right_en, lineout_en, mic_left_en, port_en}, 16'h0000);
    chk(16'(main_clk_run), 16'h0000);
    // raise the gain again, clear its event, then shut down on the interrupt
    do_cmd(CCS_OP_WRITE, REG_PLAYBACK_GAIN, 8'hD5);
    wait_gain(8'hD5);
    do_cmd(CCS_OP_READ, REG_EVENT_STATUS, 8'h00);
    chk(16'(rsp_data), 16'h0040);
    do_cmd(CCS_OP_SHUT_IRQ, 8'h00, 8'h00);
    chk(16'(rsp_data & 8'h40), 16'h0040);
    chk(16'(live_gain), 16'h0080);
    chk(16'(bus_if.interrupt_out_n), 16'h0001);
    do_cmd(CCS_OP_READ, REG_EVENT_GEN_ENABLE, 8'h00);
    chk(16'(rsp_data), 16'h0040);
    // second reset in mid-run
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    chk({live_gain, 7'h00, bus_if.interrupt_out_n}, 16'h8001);
    do_cmd(CCS_OP_READ, REG_EVENT_GEN_ENABLE, 8'h00);
    chk(16'(rsp_data), 16'h0050);
    test_done();
  end
endmodule : ccs_test

/* logic/ccs_device.sv */
`timescale 1ns/10ps
module ccs_device import ccs_pkg::*; #(
  parameter int STEP_CYC = RAMP_STEP_CYC,
  parameter int SAMPLE_W = 16
) (
  input wire logic clk,                    // system clock, 10 MHz
  input wire logic nrst,                   // async reset, active low
  ccs_if.dev bus,                          // control link to the host
  input wire logic [SAMPLE_W-1:0] in_left,  // serial port left sample
  input wire logic [SAMPLE_W-1:0] in_right, // serial port right sample
  input wire logic in_valid,               // sample pair strobe
  output logic [SAMPLE_W-1:0] play_sample, // sample for the playback path
  output logic play_valid,                 // play_sample strobe
  output logic [7:0] live_gain,            // smoothed playback gain code
  output logic [3:0] rec_gain_left,        // left record gain code
  output logic [3:0] rec_gain_right,       // right record gain code
  output logic [7:0] port_ctrl,            // serial port control byte
  output logic port_en,                    // serial audio port enable
  output logic mic_left_en,                // left microphone channel
  output logic mic_right_en,               // right microphone channel
  output logic lineout_en,                 // lineout amplifier
  output logic amp_en,                     // class-D amplifier
  output logic main_clk_run                // main clock running
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] status_reg;
  logic [7:0] mask_reg;
  logic [7:0] gen_en_reg;
  logic [7:0] routing_reg;
  logic [7:0] record_gain_reg;
  logic [7:0] playback_gain_reg;
  logic [7:0] chan_reg;
  logic [7:0] status_next;
  logic [7:0] event_set;
  logic [7:0] rdata_next;
  logic take;
  logic wr;
  logic rd_status;
  logic ramp_done;
  logic clk_ready_pulse;
  logic [7:0] ramp_level;
  logic ack_reg;
  logic [7:0] rdata_reg;
  logic irq_n_reg;

  // a request is taken once; the held req is ignored while ack stands
  assign take = bus.req && !ack_reg;
  assign wr = take && bus.we;
  assign rd_status = take && !bus.we && (bus.addr == REG_EVENT_STATUS);

  // read decode, unmapped and write-only offsets read as zero
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    case (a)
      REG_EVENT_STATUS: read_mux = status_reg;
      REG_EVENT_IRQ_MASK: read_mux = mask_reg;
      REG_EVENT_GEN_ENABLE: read_mux = gen_en_reg;
      REG_AUDIO_PORT_CONTROL: read_mux = port_ctrl;
      REG_AUDIO_PORT_ROUTING: read_mux = routing_reg;
      REG_RECORD_GAIN: read_mux = record_gain_reg;
      REG_PLAYBACK_GAIN: read_mux = playback_gain_reg;
      REG_CHANNEL_ENABLES: read_mux = chan_reg;
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  assign rdata_next = read_mux(bus.addr);

  // ----------------------------------------------------------------
  // link answer
  // ----------------------------------------------------------------
  // one-cycle ack the edge after a request is taken
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ack_reg <= take;
      if (take && !bus.we) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign bus.ack = ack_reg;
  assign bus.rdata = rdata_reg;

  // ----------------------------------------------------------------
  // writable control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= RST_EVENT_IRQ_MASK;
      gen_en_reg <= RST_EVENT_GEN_ENABLE;
      port_ctrl <= RST_AUDIO_PORT_CONTROL;
      routing_reg <= RST_AUDIO_PORT_ROUTING;
      record_gain_reg <= RST_RECORD_GAIN;
      playback_gain_reg <= RST_PLAYBACK_GAIN;
      chan_reg <= RST_CHANNEL_ENABLES;
    end else if (wr) begin
      case (bus.addr)
        REG_EVENT_IRQ_MASK: mask_reg <= bus.wdata;
        REG_EVENT_GEN_ENABLE: gen_en_reg <= bus.wdata;
        REG_AUDIO_PORT_CONTROL: port_ctrl <= bus.wdata;
        REG_AUDIO_PORT_ROUTING: routing_reg <= bus.wdata;
        REG_RECORD_GAIN: record_gain_reg <= bus.wdata;
        REG_PLAYBACK_GAIN: playback_gain_reg <= bus.wdata;
        REG_CHANNEL_ENABLES: chan_reg <= bus.wdata;
        default: begin
        end
      endcase
    end
  end

  // the record gain and channel enable bytes and the ramp level drive the block's outputs through flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rec_gain_left <= 4'h0;
      rec_gain_right <= 4'h0;
      port_en <= 1'b0;
      mic_left_en <= 1'b0;
      mic_right_en <= 1'b0;
      lineout_en <= 1'b0;
      amp_en <= 1'b0;
      live_gain <= RST_PLAYBACK_GAIN;
    end else begin
      rec_gain_left <= record_gain_reg[7:4];
      rec_gain_right <= record_gain_reg[3:0];
      port_en <= chan_reg[CH_PORT_BIT];
      mic_left_en <= chan_reg[CH_MIC_L_BIT];
      mic_right_en <= chan_reg[CH_MIC_R_BIT];
      lineout_en <= chan_reg[CH_LINEOUT_BIT];
      amp_en <= chan_reg[CH_AMP_BIT];
      live_gain <= ramp_level;
    end
  end

  // ----------------------------------------------------------------
  // smoothed playback gain
  // ----------------------------------------------------------------
  ccs_ramp #(
    .STEP_CYC(STEP_CYC)
  ) u_ramp (
    .clk(clk),
    .nrst(nrst),
    .target(playback_gain_reg),
    .level(ramp_level),
    .done(ramp_done)
  );

  // ----------------------------------------------------------------
  // main clock command
  // ----------------------------------------------------------------
  // the command byte is write-only; only the run state is kept
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      main_clk_run <= 1'b0;
      clk_ready_pulse <= 1'b0;
    end else begin
      clk_ready_pulse <= 1'b0;
      if (wr && bus.addr == REG_CLOCK_COMMAND) begin
        if (bus.wdata == CMD_CLK_STOP) begin
          main_clk_run <= 1'b0;
        end else if (bus.wdata == CMD_CLK_START) begin
          main_clk_run <= 1'b1;
          clk_ready_pulse <= !main_clk_run;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // events, status and interrupt
  // ----------------------------------------------------------------
  // events are pulses at completion, so each is reported once
  always_comb begin
    event_set = 8'h00;
    event_set[VOL_DONE_BIT] = ramp_done;
    event_set[CLK_READY_BIT] = clk_ready_pulse;
    event_set = event_set & gen_en_reg;
  end

  // a status read clears the byte but a same-cycle event survives
  always_comb begin
    status_next = rd_status ? event_set : (status_reg | event_set);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_reg <= RST_EVENT_STATUS;
    end else begin
      status_reg <= status_next;
    end
  end

  // interrupt follows the status byte that is about to stand
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= ~|(status_next & mask_reg);
    end
  end

  assign bus.interrupt_out_n = irq_n_reg;

  // ----------------------------------------------------------------
  // playback source selection
  // ----------------------------------------------------------------
  // mean is taken at one extra bit so the sum cannot wrap
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      play_sample <= '0;
      play_valid <= 1'b0;
    end else begin
      play_valid <= in_valid && port_en;
      if (in_valid) begin
        case (routing_reg[ROUTE_LSB+:2])
          ROUTE_RIGHT: play_sample <= in_right;
          ROUTE_MEAN: play_sample <= SAMPLE_W'(({in_left[SAMPLE_W-1], in_left}
                                   + {in_right[SAMPLE_W-1], in_right}) >>> 1);
          default: play_sample <= in_left;
        endcase
      end
    end
  end

endmodule : ccs_device

/* logic/ccs_host.sv */
`timescale 1ns/10ps
module ccs_host import ccs_pkg::*; (
  input wire logic clk,         // system clock, 10 MHz
  input wire logic nrst,        // async reset, active low
  ccs_if.host bus,              // control link to the device
  input wire logic cmd_valid,   // command request
  input wire ccs_op_t cmd_op,   // operation
  input wire logic [7:0] cmd_addr, // register offset for read/write
  input wire logic [7:0] cmd_data, // write data
  output logic cmd_ready,       // idle, a command may be given
  output logic rsp_valid,       // one-cycle completion pulse
  output logic [7:0] rsp_data   // read data or last status read
);
  typedef enum {
    ST_IDLE, ST_USER, ST_MUTE, ST_MASK, ST_GEN, ST_WAIT_IRQ,
    ST_READ_STATUS, ST_DISABLE, ST_STOP
  } ccs_hstate_t;

  ccs_hstate_t state_reg;
  logic irq_mode_reg;
  logic pend_reg;

  // each step issues one access; req stands until the device acks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      irq_mode_reg <= 1'b0;
      pend_reg <= 1'b0;
      bus.req <= 1'b0;
      bus.we <= 1'b0;
      bus.addr <= 8'h00;
      bus.wdata <= 8'h00;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      if (bus.ack) begin
        bus.req <= 1'b0;
        pend_reg <= 1'b0;
      end
      // a queued access goes out the cycle after the last ack, so req idles one cycle
      if (pend_reg && !bus.req && !bus.ack) begin
        bus.req <= 1'b1;
      end
      case (state_reg)
        ST_IDLE: begin
          if (cmd_valid) begin
            cmd_ready <= 1'b0;
            irq_mode_reg <= (cmd_op == CCS_OP_SHUT_IRQ);
            pend_reg <= 1'b1;
            bus.req <= 1'b1;
            if (cmd_op == CCS_OP_WRITE || cmd_op == CCS_OP_READ) begin
              bus.we <= (cmd_op == CCS_OP_WRITE);
              bus.addr <= cmd_addr;
              bus.wdata <= cmd_data;
              state_reg <= ST_USER;
            end else begin
              // mute always comes first; harmless when the amp is off
              bus.we <= 1'b1;
              bus.addr <= REG_PLAYBACK_GAIN;
              bus.wdata <= PB_MUTE;
              state_reg <= ST_MUTE;
            end
          end
        end
        ST_USER: begin
          if (bus.ack) begin
            rsp_data <= bus.we ? rsp_data : bus.rdata;
            rsp_valid <= 1'b1;
            cmd_ready <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_MUTE: begin
          if (bus.ack) begin
            pend_reg <= 1'b1;
            bus.addr <= REG_EVENT_IRQ_MASK;
            bus.wdata <= irq_mode_reg ? IRQ_ONLY_VOL : ALL_CLEAR;
            state_reg <= ST_MASK;
          end
        end
        ST_MASK: begin
          if (bus.ack) begin
            pend_reg <= irq_mode_reg;
            bus.we <= irq_mode_reg;
            bus.addr <= irq_mode_reg ? REG_EVENT_GEN_ENABLE : REG_EVENT_STATUS;
            bus.wdata <= IRQ_ONLY_VOL;
            state_reg <= irq_mode_reg ? ST_GEN : ST_READ_STATUS;
          end
        end
        ST_GEN: begin
          if (bus.ack) begin
            state_reg <= ST_WAIT_IRQ;
          end
        end
        ST_WAIT_IRQ: begin
          if (!bus.interrupt_out_n) begin
            bus.req <= 1'b1;
            pend_reg <= 1'b1;
            bus.we <= 1'b0;
            bus.addr <= REG_EVENT_STATUS;
            state_reg <= ST_READ_STATUS;
          end
        end
        ST_READ_STATUS: begin
          if (!pend_reg && !bus.req) begin
            bus.req <= 1'b1; // first poll after the mask step
            pend_reg <= 1'b1;
          end else if (bus.ack) begin
            rsp_data <= bus.rdata;
            pend_reg <= 1'b1;
            if (bus.rdata[VOL_DONE_BIT]) begin
              bus.we <= 1'b1;
              bus.addr <= REG_CHANNEL_ENABLES;
              bus.wdata <= ALL_CLEAR;
              state_reg <= ST_DISABLE;
            end
            // otherwise the same status read repeats
          end
        end
        ST_DISABLE: begin
          if (bus.ack) begin
            pend_reg <= 1'b1;
            bus.addr <= REG_CLOCK_COMMAND;
            bus.wdata <= CMD_CLK_STOP;
            state_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (bus.ack) begin
            rsp_valid <= 1'b1;
            cmd_ready <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule : ccs_host

/* logic/ccs_if.sv */
`timescale 1ns/10ps
interface ccs_if;
  logic req;             // host request, held until ack
  logic we;              // 1 write, 0 read
  logic [7:0] addr;      // register offset
  logic [7:0] wdata;     // write data
  logic ack;             // one-cycle answer from the device
  logic [7:0] rdata;     // read data, valid with ack
  logic interrupt_out_n; // active-low interrupt from the device

  modport dev (input req, input we, input addr, input wdata,
               output ack, output rdata, output interrupt_out_n);
  modport host (output req, output we, output addr, output wdata,
                input ack, input rdata, input interrupt_out_n);
endinterface : ccs_if

/* logic/ccs_pkg.sv */
package ccs_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_EVENT_STATUS = 8'h00;
  localparam logic [7:0] REG_EVENT_IRQ_MASK = 8'h01;
  localparam logic [7:0] REG_EVENT_GEN_ENABLE = 8'h02;
  localparam logic [7:0] REG_AUDIO_PORT_CONTROL = 8'h09;
  localparam logic [7:0] REG_AUDIO_PORT_ROUTING = 8'h0A;
  localparam logic [7:0] REG_RECORD_GAIN = 8'h0F;
  localparam logic [7:0] REG_PLAYBACK_GAIN = 8'h2A;
  localparam logic [7:0] REG_CHANNEL_ENABLES = 8'h32;
  localparam logic [7:0] REG_CLOCK_COMMAND = 8'h33;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_EVENT_STATUS = 8'h00;
  localparam logic [7:0] RST_EVENT_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_EVENT_GEN_ENABLE = 8'h50;
  localparam logic [7:0] RST_AUDIO_PORT_CONTROL = 8'h00;
  localparam logic [7:0] RST_AUDIO_PORT_ROUTING = 8'h00;
  localparam logic [7:0] RST_RECORD_GAIN = 8'h00;
  localparam logic [7:0] RST_PLAYBACK_GAIN = 8'h80;
  localparam logic [7:0] RST_CHANNEL_ENABLES = 8'h00;

  // ----------------------------------------------------------------
  // field positions and codes
  // ----------------------------------------------------------------
  localparam int VOL_DONE_BIT = 6;
  localparam int CLK_READY_BIT = 4;
  localparam int CH_PORT_BIT = 0;
  localparam int CH_MIC_L_BIT = 1;
  localparam int CH_LINEOUT_BIT = 2;
  localparam int CH_MIC_R_BIT = 3;
  localparam int CH_AMP_BIT = 5;
  localparam int ROUTE_LSB = 2;
  localparam logic [1:0] ROUTE_LEFT = 2'h0;
  localparam logic [1:0] ROUTE_RIGHT = 2'h1;
  localparam logic [1:0] ROUTE_MEAN = 2'h2;
  localparam logic [7:0] CMD_CLK_STOP = 8'h00;
  localparam logic [7:0] CMD_CLK_START = 8'h01;
  localparam logic [7:0] PB_MUTE = 8'h80;
  localparam logic [7:0] IRQ_ONLY_VOL = 8'h40;
  localparam logic [7:0] ALL_CLEAR = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int RAMP_STEP_NS = 1000;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // host command operations
  typedef enum logic [1:0] {
    CCS_OP_WRITE,
    CCS_OP_READ,
    CCS_OP_SHUT_POLL,
    CCS_OP_SHUT_IRQ
  } ccs_op_t;

endpackage : ccs_pkg

/* logic/ccs_ramp.sv */
`timescale 1ns/10ps
// smoothed gain stepper: walks the live code one step toward the target
module ccs_ramp import ccs_pkg::*; #(
  parameter int STEP_CYC = RAMP_STEP_CYC
) (
  input wire logic clk,          // system clock
  input wire logic nrst,         // async reset, active low
  input wire logic [7:0] target, // requested gain code
  output logic [7:0] level,      // live gain code
  output logic done              // one-cycle pulse when a ramp ends
);
  logic [15:0] tick_reg;
  logic moving_reg;
  logic tick;

  assign tick = (tick_reg == 16'(STEP_CYC - 1));

  // step pacing; a free-running divider keeps the ramp slope fixed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_reg <= 16'h0000;
    end else if (tick) begin
      tick_reg <= 16'h0000;
    end else begin
      tick_reg <= tick_reg + 16'h0001;
    end
  end

  // one code per tick instead of a jump avoids audible clicks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level <= RST_PLAYBACK_GAIN;
      moving_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (tick && level != target) begin
        level <= (level < target) ? level + 8'h01 : level - 8'h01;
        moving_reg <= 1'b1;
      end else if (tick && moving_reg) begin
        moving_reg <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule : ccs_ramp
